/* inc/acr_pkg.sv */
// Constants, register map and field layout of the converter clock tree.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register port.
package acr_pkg;
	// Clock and timing
	localparam int CLK_SYS_MHZ = 50;
	localparam int XTAL_STARTUP_MS = 5;
	localparam int XTAL_STARTUP_CYCLES = XTAL_STARTUP_MS * 1000 * CLK_SYS_MHZ;

	// Register byte offsets
	localparam logic [3:0] OFS_CLOCK_CONFIG_ONE = 4'h0;
	localparam logic [3:0] OFS_CLOCK_CONFIG_TWO = 4'h4;
	localparam logic [3:0] OFS_CHANNEL_POWER = 4'h8;
	localparam logic [3:0] OFS_CLOCK_STATUS = 4'hc;

	// Clock config one fields
	localparam int MDIV_LSB = 0;
	localparam int XTAL_EN_BIT = 6;
	localparam int CLK_SRC_BIT = 7;
	// Clock config two fields
	localparam int OSR_LSB = 0;
	localparam int MODDIV_LSB = 4;
	// Status fields
	localparam int ST_OSC_READY_BIT = 0;
	localparam int ST_SERIAL_OK_BIT = 1;
	localparam int ST_MODE_LSB = 2;
	localparam int ST_REFUSED_BIT = 4;
	localparam int ST_RUNNING_BIT = 5;

	// Reset values
	localparam logic [7:0] RST_CLOCK_CONFIG_ONE = 8'h08;
	localparam logic [7:0] RST_CLOCK_CONFIG_TWO = 8'h86;
	localparam logic [3:0] RST_CHANNEL_POWER = 4'h0;

	localparam int NUM_CHANNELS = 4;
	localparam int DIV_W = 13;

	// Interface modes seen on the mode pins
	typedef enum logic [1:0] {
		ACR_MODE_ASYNC_IRQ = 2'h0,
		ACR_MODE_SYNC_MASTER = 2'h1,
		ACR_MODE_SYNC_SLAVE = 2'h2
	} acr_mode_t;

	// 3-bit divider code to factor: 0 and 1 give 2, otherwise 2 x code
	function automatic logic [DIV_W-1:0] acr_div_factor(input logic [2:0] code);
		acr_div_factor = (code < 3'h2) ? 13'h0002 : {9'h000, code, 1'b0};
	endfunction

	// Oversampling ratio for each 4-bit code
	function automatic logic [DIV_W-1:0] acr_osr_factor(input logic [3:0] code);
		unique case (code)
			4'h0: acr_osr_factor = 13'h1000;
			4'h1: acr_osr_factor = 13'h0800;
			4'h2: acr_osr_factor = 13'h0400;
			4'h3: acr_osr_factor = 13'h0320;
			4'h4: acr_osr_factor = 13'h0300;
			4'h5: acr_osr_factor = 13'h0200;
			4'h6: acr_osr_factor = 13'h0190;
			4'h7: acr_osr_factor = 13'h0180;
			4'h8: acr_osr_factor = 13'h0100;
			4'h9: acr_osr_factor = 13'h00c8;
			4'ha: acr_osr_factor = 13'h00c0;
			4'hb: acr_osr_factor = 13'h0080;
			4'hc: acr_osr_factor = 13'h0060;
			4'hd: acr_osr_factor = 13'h0040;
			4'he: acr_osr_factor = 13'h0030;
			4'hf: acr_osr_factor = 13'h0020;
		endcase
	endfunction
endpackage

/* hw/acr_tick_div.sv */
// Divides a stream of one-cycle ticks by a run-time factor.
// Assumes the factor is at least 1 and the ticks are synchronous to clk_sys.
`timescale 1ns/100ps
module acr_tick_div (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Control
	input wire logic clear,
	input wire logic [12:0] divisor,
	// Ticks
	input wire logic tickIn,
	output logic tickOut
);
	import acr_pkg::*;

	logic [DIV_W-1:0] count;
	wire logic [DIV_W-1:0] lastCount = divisor - 13'h0001;
	// Wrap also past the end, in case the factor shrank mid-count
	wire logic atEnd = (count >= lastCount);

	always_ff @(posedge clk_sys) begin
		if (srst || clear) begin
			count <= '0;
			tickOut <= 1'b0;
		end else begin
			tickOut <= tickIn && atEnd;
			if (tickIn) begin
				count <= atEnd ? '0 : count + 13'h0001;
			end
		end
	end
endmodule

/* hw/acr_clock_tree.sv */
// Clock tree and rate select of a multichannel delta-sigma converter.
// Pins are sampled on clk_sys, so the master and serial clocks must run well below 25 MHz.
// Derived clocks are one-cycle ticks on clk_sys, not separate clock nets.
`timescale 1ns/100ps

module acr_clock_tree #(
	parameter int XTAL_STARTUP = acr_pkg::XTAL_STARTUP_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Clock pins
	input wire logic oscillatorInPin,
	output logic oscillatorOutPin,
	output logic oscillatorOutOe,
	input wire logic serialClockIn,
	output logic serialClockOut,
	output logic serialClockOe,
	input wire logic [1:0] interfaceModePin,
	// Derived timing
	output logic systemClockTick,
	output logic modulatorClockTick,
	output logic [acr_pkg::NUM_CHANNELS-1:0] channelSample,
	output logic conversionReady
);
	import acr_pkg::*;

	// Pin synchronisers: a level counts once stages two and three agree
	localparam int NPIN = 4;
	wire logic [NPIN-1:0] pinRaw = {interfaceModePin, serialClockIn, oscillatorInPin};
	logic [NPIN-1:0] pinStable;
	logic [NPIN-1:0] pinRise;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			// Local flops so each vector has a single driver
			logic s1, s2, s3, stable, rise;
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					stable <= 1'b0;
					rise <= 1'b0;
				end else begin
					s1 <= pinRaw[gi];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						stable <= s2;
					end
					rise <= (s2 == s3) && s2 && !stable;
				end
			end
			assign pinStable[gi] = stable;
			assign pinRise[gi] = rise;
		end
	endgenerate

	wire logic oscEdge = pinRise[0];
	wire logic serialEdge = pinRise[1];
	wire logic [1:0] modeCode = pinStable[3:2];
	wire logic masterMode = (modeCode == ACR_MODE_SYNC_MASTER);
	wire logic slaveMode = (modeCode == ACR_MODE_SYNC_SLAVE);

	// Registers
	logic [7:0] clockConfigOne;
	logic [7:0] clockConfigTwo;
	logic [NUM_CHANNELS-1:0] channelPower;
	logic changeRefused;
	logic busAck;

	wire logic [2:0] masterDivCode = clockConfigOne[MDIV_LSB +: 3];
	wire logic crystalEnable = clockConfigOne[XTAL_EN_BIT];
	wire logic sourceSerial = clockConfigOne[CLK_SRC_BIT];
	wire logic [3:0] osrCode = clockConfigTwo[OSR_LSB +: 4];
	wire logic [2:0] modDivCode = clockConfigTwo[MODDIV_LSB +: 3];
	wire logic anyChannelOn = |channelPower;

	// Bus decode: one wait state, write lands on the acknowledging edge
	wire logic busReq = avs_read || avs_write;
	wire logic wrStrobe = avs_write && busAck && avs_byteenable[0];
	wire logic wrOne = wrStrobe && (avs_address == OFS_CLOCK_CONFIG_ONE);
	wire logic wrTwo = wrStrobe && (avs_address == OFS_CLOCK_CONFIG_TWO);
	wire logic wrPower = wrStrobe && (avs_address == OFS_CHANNEL_POWER);
	wire logic wrStatus = wrStrobe && (avs_address == OFS_CLOCK_STATUS);
	wire logic clockWriteBusy = (wrOne || wrTwo) && anyChannelOn;
	wire logic clrRefused = wrStatus && avs_writedata[ST_REFUSED_BIT];

	assign avs_waitrequest = busReq && !busAck;

	// Crystal start-up timer
	logic [17:0] startupCount;
	logic oscReady;
	wire logic startupDone = (startupCount >= 18'(XTAL_STARTUP));

	wire logic [7:0] statusByte = {2'h0, systemClockTick || modulatorClockTick, changeRefused,
		modeCode, sourceSerial && slaveMode, oscReady};
	logic [7:0] readByte;
	always_comb begin
		unique case (avs_address)
			OFS_CLOCK_CONFIG_ONE: readByte = clockConfigOne;
			OFS_CLOCK_CONFIG_TWO: readByte = clockConfigTwo;
			OFS_CHANNEL_POWER: readByte = {4'h0, channelPower};
			OFS_CLOCK_STATUS: readByte = statusByte;
			default: readByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			busAck <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			busAck <= busReq && !busAck;
			if (avs_read && !busAck) begin
				avs_readdata <= {24'h00_0000, readByte};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			clockConfigOne <= RST_CLOCK_CONFIG_ONE;
			clockConfigTwo <= RST_CLOCK_CONFIG_TWO;
			channelPower <= RST_CHANNEL_POWER;
			changeRefused <= 1'b0;
		end else begin
			if (wrOne && !anyChannelOn) begin
				clockConfigOne <= avs_writedata[7:0];
			end
			if (wrTwo && !anyChannelOn) begin
				clockConfigTwo <= avs_writedata[7:0];
			end
			if (wrPower) begin
				channelPower <= avs_writedata[NUM_CHANNELS-1:0];
			end
			// Set wins over a clear in the same cycle
			changeRefused <= clockWriteBusy || (changeRefused && !clrRefused);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			startupCount <= '0;
			oscReady <= 1'b0;
			oscillatorOutPin <= 1'b0;
			oscillatorOutOe <= 1'b0;
		end else begin
			oscillatorOutOe <= crystalEnable;
			oscillatorOutPin <= crystalEnable && !pinStable[0];
			if (!crystalEnable) begin
				startupCount <= '0;
			end else if (!startupDone) begin
				startupCount <= startupCount + 18'h00001;
			end
			oscReady <= !crystalEnable || startupDone;
		end
	end

	wire logic oscPathTick;
	acr_tick_div u_master_div (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear(1'b0),
		.divisor(acr_div_factor(masterDivCode)),
		.tickIn(oscEdge && !sourceSerial),
		.tickOut(oscPathTick)
	);

	// serial path only in slave mode
	logic serialPathTick;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			serialPathTick <= 1'b0;
		end else begin
			serialPathTick <= serialEdge && sourceSerial && slaveMode;
		end
	end

	assign systemClockTick = sourceSerial ? serialPathTick : oscPathTick;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			serialClockOut <= 1'b0;
			serialClockOe <= 1'b0;
		end else begin
			serialClockOe <= masterMode;
			if (!masterMode) begin
				serialClockOut <= 1'b0;
			end else if (systemClockTick) begin
				serialClockOut <= !serialClockOut;
			end
		end
	end

	// modulator divider, held clear while idle
	acr_tick_div u_mod_div (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear(!anyChannelOn),
		.divisor(acr_div_factor(modDivCode)),
		.tickIn(systemClockTick),
		.tickOut(modulatorClockTick)
	);

	// one rate divider for all channels
	wire logic dataTick;
	acr_tick_div u_osr_div (
		.clk_sys(clk_sys),
		.srst(srst),
		.clear(!anyChannelOn),
		.divisor(acr_osr_factor(osrCode)),
		.tickIn(modulatorClockTick),
		.tickOut(dataTick)
	);

	assign channelSample = channelPower & {NUM_CHANNELS{modulatorClockTick}};
	assign conversionReady = dataTick;

	// Assertions
	sequence s_oscTickStable;
		!sourceSerial && $past(!sourceSerial) && systemClockTick;
	endsequence
	sequence s_serialTickStable;
		sourceSerial && $past(sourceSerial) && systemClockTick;
	endsequence

	property p_oscFromEdge;
		@(posedge clk_sys) disable iff (srst) s_oscTickStable |-> $past(oscEdge);
	endproperty
	a_oscFromEdge: assert property (p_oscFromEdge) else $error("system tick without osc edge");

	property p_serialOnlySlave;
		@(posedge clk_sys) disable iff (srst)
		(sourceSerial && !slaveMode)[*2] |-> !systemClockTick;
	endproperty
	a_serialOnlySlave: assert property (p_serialOnlySlave) else $error("serial source outside slave");

	property p_serialFromEdge;
		@(posedge clk_sys) disable iff (srst) s_serialTickStable |-> $past(serialEdge && slaveMode);
	endproperty
	a_serialFromEdge: assert property (p_serialFromEdge) else $error("serial tick without edge");

	property p_modFromSys;
		@(posedge clk_sys) disable iff (srst) modulatorClockTick |-> $past(systemClockTick);
	endproperty
	a_modFromSys: assert property (p_modFromSys) else $error("modulator tick without system tick");

	property p_dataFromMod;
		@(posedge clk_sys) disable iff (srst) conversionReady |-> $past(modulatorClockTick);
	endproperty
	a_dataFromMod: assert property (p_dataFromMod) else $error("data tick without modulator tick");

	property p_sameRate;
		@(posedge clk_sys) disable iff (srst) (channelSample != '0) |-> (channelSample == channelPower);
	endproperty
	a_sameRate: assert property (p_sameRate) else $error("channels sampled unevenly");

	sequence s_busyClockWrite;
		(wrOne || wrTwo) && anyChannelOn;
	endsequence
	property p_noChangeWhileOn;
		@(posedge clk_sys) disable iff (srst)
		s_busyClockWrite |=> $stable(clockConfigOne) && $stable(clockConfigTwo) && changeRefused;
	endproperty
	a_noChangeWhileOn: assert property (p_noChangeWhileOn) else $error("clock changed while powered");

	property p_masterOut;
		@(posedge clk_sys) disable iff (srst)
		(masterMode && systemClockTick) ##1 masterMode |-> serialClockOut != $past(serialClockOut);
	endproperty
	a_masterOut: assert property (p_masterOut) else $error("serial clock out missed a tick");

	property p_busAnswer;
		@(posedge clk_sys) disable iff (srst) busReq |-> ##[0:1] !avs_waitrequest;
	endproperty
	a_busAnswer: assert property (p_busAnswer) else $error("bus answer late");
endmodule

/* dv/acr_clock_source_model.sv */
// Far-side clock sources: direct clock, crystal and a serial host clock that the host can stop.
// Assumes every half period is several clk_sys cycles; edges land just after clk_sys.
`timescale 1ns/100ps
module acr_clock_source_model #(
	parameter int HALF_EXT = 3,
	parameter int HALF_SER = 5,
	parameter int XTAL_DELAY = 40
) (
	// Clock
	input wire logic clk_sys,
	// Source choice
	input wire logic extOn,
	input wire logic xtalDrive,
	input wire logic serOn,
	// Pins
	output logic oscPin,
	output logic serClk
);
	int ec = 0;
	int sc = 0;
	int xc = 0;
	initial oscPin = 1'b0;
	initial serClk = 1'b0;
	always @(posedge clk_sys) begin
		xc <= xtalDrive ? xc + 1 : 0;
		ec <= (ec + 1) % HALF_EXT;
		sc <= (sc + 1) % HALF_SER;
		if (!(extOn || (xtalDrive && xc > XTAL_DELAY))) begin
			oscPin <= 1'b0;
		end else if (ec == 0) begin
			oscPin <= !oscPin;
		end
		// Stands still when the host stops it
		if (!serOn) begin
			serClk <= 1'b0;
		end else if (sc == 0) begin
			serClk <= !serClk;
		end
	end
endmodule

/* dv/adc_clock_tree_and_rate_select_test.sv */
// Self-checking bench of the converter clock tree, with a clock source model.
// Assumes the Avalon-MM timing and register layout of the clock tree hand-over.
`timescale 1ns/100ps
module adc_clock_tree_and_rate_select_test;
	import acr_pkg::*;
	localparam int LIM = 6000;
	localparam int HE = 3;
	localparam int HS = 5;
	localparam int OSRS [16] = '{4096, 2048, 1024, 800, 768, 512, 400, 384, 256, 200, 192, 128,
		96, 64, 48, 32};
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, oscPin, oscOut, oscOe, serClk, serOut, serOe, sysTick, modTick, cnvRdy;
	logic [1:0] modePin = 2'h0;
	logic [3:0] chanSample;
	logic extOn = 1'b1;
	logic serOn = 1'b0;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	wire [2:0] ticks = {cnvRdy, modTick, sysTick};

	always #10 clk_sys = !clk_sys;

	acr_clock_tree #(.XTAL_STARTUP(20)) u_acr_clock_tree (.clk_sys(clk_sys), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(4'hf), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .oscillatorInPin(oscPin), .oscillatorOutPin(oscOut),
		.oscillatorOutOe(oscOe), .serialClockIn(serClk), .serialClockOut(serOut),
		.serialClockOe(serOe), .interfaceModePin(modePin), .systemClockTick(sysTick),
		.modulatorClockTick(modTick), .channelSample(chanSample), .conversionReady(cnvRdy));

	acr_clock_source_model #(.HALF_EXT(HE), .HALF_SER(HS)) u_acr_clock_source_model (
		.clk_sys(clk_sys), .extOn(extOn), .xtalDrive(oscOe), .serOn(serOn),
		.oscPin(oscPin), .serClk(serClk));

	function automatic int divf(input int code);
		return code < 2 ? 2 : 2 * code;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			bad_count++;
			$display("BAD t=%0t timeout", $time);
			print_verdict();
		end
	end

	// Holds the request until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
		logic wt;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge clk_sys);
			wt = avs_waitrequest;
		end while (wt !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk({31'h0, wt}, 32'h0);
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rdc(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask

	// Cycles until the selected tick next shows, capped at LIM
	task gap(input int s, output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (ticks[s] !== 1'b1 && n < LIM);
	endtask

	// First intervals after a change may be short, so the third counts
	task gap3(input int s, output int n);
		repeat (3) gap(s, n);
	endtask

	initial begin
		int n, m, md, o;
		logic e;
		void'($urandom(32'h447d));
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		rdc(OFS_CLOCK_CONFIG_ONE, {24'h0, RST_CLOCK_CONFIG_ONE});
		rdc(OFS_CLOCK_CONFIG_TWO, {24'h0, RST_CLOCK_CONFIG_TWO});
		rdc(OFS_CHANNEL_POWER, 32'h0);
		rdc(4'h1, 32'h0);
		repeat (3) begin
			m = $urandom % 8;
			wr(OFS_CLOCK_CONFIG_ONE, m[7:0]);
			gap3(0, n);
			chk(n, 2 * HE * divf(m));
		end
		$display("test reset and master divider done");
		md = $urandom % 4;
		o = 13 + $urandom % 3;
		wr(OFS_CLOCK_CONFIG_ONE, 8'h00);
		wr(OFS_CLOCK_CONFIG_TWO, {1'b0, md[2:0], o[3:0]});
		wr(OFS_CHANNEL_POWER, 8'h0f);
		gap3(1, n);
		chk(n, 4 * HE * divf(md));
		chk({28'h0, chanSample}, 32'hf);
		gap3(2, n);
		chk(n, 4 * HE * divf(md) * OSRS[o]);
		wr(OFS_CHANNEL_POWER, 8'h05);
		gap3(1, n);
		chk({28'h0, chanSample}, 32'h5);
		// Stop the pin clock so the status tick bit reads zero
		@(posedge clk_sys);
		extOn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		wr(OFS_CLOCK_CONFIG_TWO, 8'h00);
		wr(OFS_CLOCK_CONFIG_ONE, 8'h07);
		rdc(OFS_CLOCK_CONFIG_TWO, {24'h0, 1'b0, md[2:0], o[3:0]});
		rdc(OFS_CLOCK_CONFIG_ONE, 32'h0);
		rdc(OFS_CLOCK_STATUS, 32'h11);
		wr(OFS_CHANNEL_POWER, 8'h00);
		wr(OFS_CLOCK_STATUS, 8'h10);
		rdc(OFS_CLOCK_STATUS, 32'h01);
		// Clock runs again, channels off: no modulator ticks
		@(posedge clk_sys);
		extOn <= 1'b1;
		gap(1, n);
		chk(n, LIM);
		$display("test modulator and rate done");
		@(posedge clk_sys);
		extOn <= 1'b0;
		serOn <= 1'b1;
		wr(OFS_CLOCK_CONFIG_ONE, 8'h80);
		repeat (8) @(posedge clk_sys);
		gap(0, n);
		chk(n, LIM);
		chk({31'h0, serOe}, 32'h0);
		@(posedge clk_sys);
		modePin <= 2'h2;
		gap3(0, n);
		chk(n, 2 * HS);
		@(posedge clk_sys);
		serOn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rdc(OFS_CLOCK_STATUS, 32'h0b);
		$display("test serial source done");
		@(posedge clk_sys);
		modePin <= 2'h1;
		extOn <= 1'b1;
		serOn <= 1'b0;
		m = 2 + $urandom % 6;
		wr(OFS_CLOCK_CONFIG_ONE, m[7:0]);
		gap3(0, n);
		chk(n, 2 * HE * divf(m));
		e = serOut;
		@(negedge clk_sys);
		chk({31'h0, serOut}, {31'h0, !e});
		chk({31'h0, serOe}, 32'h1);
		$display("test master mode done");
		@(posedge clk_sys);
		modePin <= 2'h0;
		extOn <= 1'b0;
		wr(OFS_CLOCK_CONFIG_ONE, 8'h40);
		gap3(0, n);
		chk(n, 4 * HE);
		chk({31'h0, oscOe}, 32'h1);
		// Inverter drive is high for half of four whole pin periods
		o = 0;
		repeat (24) begin
			@(negedge clk_sys);
			o = o + ((oscOut === 1'b1) ? 1 : 0);
		end
		chk(o, 12);
		$display("test crystal done");
		print_verdict();
	end
endmodule
